// File: ppc_pkg.sv
// shared constants and types for the converter link
package ppc_pkg;

    // sample word and pipeline depth
    localparam int DATA_W = 8;
    localparam int PIPE_STAGES = 24;
    localparam int LATENCY = 28;
    localparam int CORR_STAGES = LATENCY - PIPE_STAGES;

    // clock and calibration timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CAL_TIME_MS = 190;
    localparam int unsigned CAL_CYCLES_DFLT = CAL_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int CAL_CNT_W = 24;
    localparam int RST_LOW_NS = 40;
    localparam int RST_LOW_CYCLES = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 4;

    // levels seen on strap pins nobody drives
    localparam logic DIV_N_PULL = 1'b0;
    localparam logic TC_N_PULL = 1'b1;
    localparam logic REF_PULL = 1'b1;

    // capture-side register map
    localparam int REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_FREQ = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [REG_ADDR_W-1:0] REG_DATA = 4'hC;

    localparam int CTRL_W = 7;
    localparam int CTRL_RECAL = 0;
    localparam int CTRL_DIV_VAL = 1;
    localparam int CTRL_DIV_OE = 2;
    localparam int CTRL_TC_VAL = 3;
    localparam int CTRL_TC_OE = 4;
    localparam int CTRL_REF_VAL = 5;
    localparam int CTRL_REF_OE = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

    localparam int STAT_BUSY = 0;
    localparam int STAT_NEW = 1;
    localparam int STAT_RST = 2;
    localparam int DATA_OVR_BIT = 8;

    localparam int FREQ_W = 16;
    localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h61A8;
    localparam int DRIFT_W = FREQ_W + 7;
    localparam int DRIFT_LIMIT_PCT = 10;
    localparam int PCT_FULL = 100;

    typedef enum logic [1:0] {ST_HOLD, ST_RESET, ST_CAL, ST_RUN} ppc_state_t;

endpackage

// File: ppc_link_if.sv
// pins between the converter and the capture logic
`timescale 1ns/1ns
interface ppc_link_if;
    import ppc_pkg::*;

    logic [DATA_W-1:0] data;
    logic ovr;
    logic fwd_clk;
    logic dev_rst_n_out;
    logic dev_rst_n_oe;
    logic cap_rst_n_out;
    logic cap_rst_n_oe;
    logic rst_n;
    logic div_n_val;
    logic div_n_oe;
    logic tc_n_val;
    logic tc_n_oe;
    logic ref_val;
    logic ref_oe;

    // open-drain reset line with pull-up
    assign rst_n = !((dev_rst_n_oe && !dev_rst_n_out) || (cap_rst_n_oe && !cap_rst_n_out));

    modport device (
        input rst_n, div_n_val, div_n_oe, tc_n_val, tc_n_oe, ref_val, ref_oe,
        output data, ovr, fwd_clk, dev_rst_n_out, dev_rst_n_oe
    );

    modport capture (
        input data, ovr, fwd_clk, rst_n,
        output cap_rst_n_out, cap_rst_n_oe, div_n_val, div_n_oe, tc_n_val, tc_n_oe,
        output ref_val, ref_oe
    );

endinterface

// File: ppc_delay_line.sv
// shift delay advancing on a sample tick
`timescale 1ns/1ns
module ppc_delay_line #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic adv_i,
    input wire logic [WIDTH-1:0] din_i,
    output logic [WIDTH-1:0] dout_o
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (adv_i) begin
            mem_r[0] <= din_i;
            for (int i = 1; i < DEPTH; i++) begin
                mem_r[i] <= mem_r[i-1];
            end
        end
    end

    assign dout_o = mem_r[DEPTH-1];

endmodule

// File: ppc_converter.sv
// converter end: output pipeline, calibration and clock control
//
// Design decisions made at the capture end: the address map and the strobed register port.
`timescale 1ns/1ns
module ppc_converter
    import ppc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = CAL_CYCLES_DFLT
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [DATA_W-1:0] analog_code_i,
    input wire logic analog_over_i,
    output logic cal_active_o,
    output logic ref_internal_o,
    ppc_link_if.device link
);

    ppc_state_t state_r;
    ppc_state_t state_nxt;
    logic line_low;
    logic div_sel;
    logic tc_sel;
    logic ref_sel;
    logic div_r;
    logic tick;
    logic [CAL_CNT_W-1:0] cal_cnt_r;
    logic cal_done;
    logic [DATA_W:0] acq;
    logic [DATA_W:0] pipe_out;
    logic [DATA_W:0] corr_out;
    logic [DATA_W-1:0] data_r;
    logic ovr_r;
    logic fwd_r;
    logic hold_oe_r;
    logic hold_out_r;
    logic cal_active_r;
    logic ref_internal_r;

    // reset pin as seen on the shared line
    assign line_low = !link.rst_n;

    // undriven strap pins fall back to their pulls
    assign div_sel = link.div_n_oe ? link.div_n_val : DIV_N_PULL;
    assign tc_sel = link.tc_n_oe ? link.tc_n_val : TC_N_PULL;
    assign ref_sel = link.ref_oe ? link.ref_val : REF_PULL;

    // internal sample clock: toggle flop on rising edges only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || line_low) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    // first tick lands on the first edge after the line releases
    assign tick = div_sel ? 1'b1 : !div_r;

    // calibration timer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || state_r != state_nxt) begin
            cal_cnt_r <= '0;
        end else if (state_r == ST_HOLD || state_r == ST_CAL) begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
        end
    end

    assign cal_done = (cal_cnt_r == CAL_CNT_W'(CAL_CYCLES - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: begin
                if (cal_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RESET: begin
                if (!line_low) begin
                    state_nxt = ST_CAL;
                end
            end
            ST_CAL: begin
                if (line_low) begin
                    state_nxt = ST_RESET;
                end else if (cal_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (line_low) begin
                    state_nxt = ST_RESET;
                end
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // power-up hold of the reset line
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_oe_r <= 1'b1;
        end else begin
            hold_oe_r <= (state_nxt == ST_HOLD);
        end
    end

    always_ff @(posedge clk_i) begin
        hold_out_r <= 1'b0;
    end

    // conversion pipeline then error correction
    assign acq = {analog_over_i, analog_code_i};

    ppc_delay_line #(
        .WIDTH(DATA_W + 1),
        .DEPTH(PIPE_STAGES)
    ) u_conv (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .adv_i(tick),
        .din_i(acq),
        .dout_o(pipe_out)
    );

    // correction stages, then the output register
    ppc_delay_line #(
        .WIDTH(DATA_W + 1),
        .DEPTH(CORR_STAGES)
    ) u_corr (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .adv_i(tick),
        .din_i(pipe_out),
        .dout_o(corr_out)
    );

    // output word, msb flipped for twos complement
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            data_r <= '0;
        end else if (tick) begin
            if (tc_sel) begin
                data_r <= corr_out[DATA_W-1:0];
            end else begin
                data_r <= {~corr_out[DATA_W-1], corr_out[DATA_W-2:0]};
            end
        end
    end

    // over-range flag
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ovr_r <= 1'b1;
        end else if (state_nxt != ST_RUN || line_low) begin
            ovr_r <= 1'b1;
        end else if (tick) begin
            ovr_r <= corr_out[DATA_W];
        end
    end

    // forwarded clock: one transition per output word
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || line_low) begin
            fwd_r <= 1'b0;
        end else if (tick) begin
            fwd_r <= ~fwd_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cal_active_r <= 1'b1;
        end else begin
            cal_active_r <= (state_nxt != ST_RUN);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ref_internal_r <= 1'b0;
        end else begin
            ref_internal_r <= !ref_sel;
        end
    end

    assign link.data = data_r;
    assign link.ovr = ovr_r;
    assign link.fwd_clk = fwd_r;
    assign link.dev_rst_n_oe = hold_oe_r;
    assign link.dev_rst_n_out = hold_out_r;
    assign cal_active_o = cal_active_r;
    assign ref_internal_o = ref_internal_r;

endmodule

// File: ppc_capture.sv
// capture end: word capture, straps and recalibration control
`timescale 1ns/1ns
module ppc_capture
    import ppc_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [REG_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [DATA_W-1:0] sample_o,
    output logic sample_ovr_o,
    output logic sample_valid_o,
    output logic cal_busy_o,
    ppc_link_if.capture link
);

    logic [CTRL_W-1:0] ctrl_r;
    logic [FREQ_W-1:0] freq_r;
    logic [FREQ_W-1:0] cal_freq_r;
    logic [FREQ_W-1:0] wfreq;
    logic [FREQ_W-1:0] diff;
    logic freq_wr;
    logic drift_trip;
    logic recal;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic rst_oe_r;
    logic rst_out_r;
    logic fwd_prev_r;
    logic change;
    logic busy_r;
    logic new_r;
    logic valid_r;
    logic [DATA_W-1:0] sample_r;
    logic ovr_r;
    logic [31:0] rdata_r;

    assign wfreq = wdata_i[FREQ_W-1:0];
    assign freq_wr = wr_i && addr_i == REG_FREQ;
    assign diff = (wfreq > cal_freq_r) ? wfreq - cal_freq_r : cal_freq_r - wfreq;

    // any change while busy restarts calibration
    assign drift_trip = freq_wr && ((busy_r && diff != '0) ||
        (DRIFT_W'(diff) * DRIFT_W'(PCT_FULL) >
         DRIFT_W'(cal_freq_r) * DRIFT_W'(DRIFT_LIMIT_PCT)));
    assign recal = (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_RECAL]) || drift_trip;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_i && addr_i == REG_CTRL) begin
            ctrl_r <= wdata_i[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_RECAL);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            freq_r <= FREQ_RESET;
            cal_freq_r <= FREQ_RESET;
        end else begin
            if (freq_wr) begin
                freq_r <= wfreq;
            end
            if (recal) begin
                cal_freq_r <= freq_wr ? wfreq : freq_r;
            end
        end
    end

    // open-drain pulse on the reset line
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rst_cnt_r <= '0;
            rst_oe_r <= 1'b0;
        end else begin
            if (recal) begin
                rst_cnt_r <= RST_CNT_W'(RST_LOW_CYCLES);
            end else if (rst_cnt_r != '0) begin
                rst_cnt_r <= rst_cnt_r - 1'b1;
            end
            rst_oe_r <= recal || rst_cnt_r > RST_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        rst_out_r <= 1'b0;
    end

    // each transition of the forwarded clock carries one word
    assign change = link.fwd_clk != fwd_prev_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fwd_prev_r <= 1'b0;
        end else begin
            fwd_prev_r <= link.fwd_clk;
        end
    end

    // busy until the flag is seen low again
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || recal || !link.rst_n) begin
            busy_r <= 1'b1;
        end else if (change && !link.ovr) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sample_r <= '0;
            ovr_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= change && (!busy_r || !link.ovr);
            if (change) begin
                sample_r <= link.data;
                ovr_r <= link.ovr;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            new_r <= 1'b0;
        end else if (valid_r) begin
            new_r <= 1'b1;
        end else if (rd_i && addr_i == REG_DATA) begin
            new_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                REG_CTRL: rdata_r <= 32'(ctrl_r);
                REG_FREQ: rdata_r <= 32'(freq_r);
                REG_STATUS: rdata_r <= 32'({!link.rst_n, new_r, busy_r});
                REG_DATA: rdata_r <= 32'({ovr_r, sample_r});
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign link.cap_rst_n_oe = rst_oe_r;
    assign link.cap_rst_n_out = rst_out_r;
    assign link.div_n_val = ctrl_r[CTRL_DIV_VAL];
    assign link.div_n_oe = ctrl_r[CTRL_DIV_OE];
    assign link.tc_n_val = ctrl_r[CTRL_TC_VAL];
    assign link.tc_n_oe = ctrl_r[CTRL_TC_OE];
    assign link.ref_val = ctrl_r[CTRL_REF_VAL];
    assign link.ref_oe = ctrl_r[CTRL_REF_OE];
    assign rdata_o = rdata_r;
    assign sample_o = sample_r;
    assign sample_ovr_o = ovr_r;
    assign sample_valid_o = valid_r;
    assign cal_busy_o = busy_r;

endmodule

// File: ppc_assertions.sv
// concurrent checks on the converter link
`timescale 1ns/1ns
module ppc_assertions
    import ppc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ovr,
    input wire logic fwd_clk,
    input wire logic rst_n,
    input wire logic dev_rst_n_oe,
    input wire logic cap_rst_n_oe,
    input wire logic div_n_val,
    input wire logic div_n_oe
);
    logic div_one;
    logic rst_n_r;
    logic dev_oe_r;
    logic [CAL_CNT_W-1:0] hold_cnt_r;
    logic [CAL_CNT_W-1:0] cal_cnt_r;
    assign div_one = div_n_oe ? div_n_val : DIV_N_PULL;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge clk_i) begin
        rst_n_r <= rst_n;
        dev_oe_r <= dev_rst_n_oe;
    end
    // cycles of power-up hold
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !dev_rst_n_oe) begin
            hold_cnt_r <= '0;
        end else begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end
    // cycles since a requested reset ended
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rst_n) begin
            cal_cnt_r <= '0;
        end else if (!rst_n_r && !dev_oe_r) begin
            cal_cnt_r <= CAL_CNT_W'(1);
        end else if (cal_cnt_r != '0 && cal_cnt_r != '1) begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
        end
    end
    chk_clk_stopped: assert property (!rst_n |=> !fwd_clk)
        else $error("output clock moved while reset low");
    chk_ovr_forced: assert property (!rst_n |=> ovr)
        else $error("flag low while reset low");
    chk_req_pulse: assert property ($rose(cap_rst_n_oe) |-> !rst_n ##1 !cap_rst_n_oe)
        else $error("bad recalibration pulse");
    chk_clk_resume: assert property ($rose(rst_n) |-> ##[1:2] fwd_clk)
        else $error("output clock did not resume");
    chk_cal_ovr: assert property (cal_cnt_r != 0 && cal_cnt_r < CAL_CYCLES - 2 |-> ovr)
        else $error("flag fell before calibration end");
    chk_hold_len: assert property ($fell(dev_rst_n_oe) |->
        hold_cnt_r >= CAL_CYCLES - 1 && hold_cnt_r <= CAL_CYCLES + 2)
        else $error("power-up hold length wrong");
    chk_div_two: assert property (rst_n && !div_one && !$past(div_one) &&
        !$past(div_one, 2) && $changed(fwd_clk) |=> $stable(fwd_clk))
        else $error("divided clock toggled twice in a row");
    chk_div_one: assert property ((rst_n && div_one) [*3] |=> $changed(fwd_clk))
        else $error("undivided clock missed a word");
endmodule

// File: test_ppc.sv
// self-checking bench for the converter and capture ends
`timescale 1ns/1ns
module test_ppc;
    import ppc_pkg::*;
    localparam int unsigned CAL_N = 50;
    logic clk_i;
    logic sys_rst_i;
    logic [DATA_W-1:0] code;
    logic [DATA_W-1:0] fixed_code;
    logic over;
    logic cal_active;
    logic ref_internal;
    logic [REG_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic wr_s;
    logic rd_s;
    logic [DATA_W-1:0] sample;
    logic sample_valid;
    logic sample_ovr;
    logic cal_busy;
    logic run_code;
    logic ovr_on;
    logic ovr_force;
    logic lat_on;
    logic tc_mode;
    logic [8:0] hist [0:31];
    logic [6:0] ctrl_tab [0:2] = '{7'h06, 7'h16, 7'h1E};
    int bad_count;
    int n_checks;
    int n;
    int v;
    ppc_link_if link ();
    ppc_converter #(.CAL_CYCLES(CAL_N)) ppc_converter_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .analog_code_i(code), .analog_over_i(over), .cal_active_o(cal_active),
        .ref_internal_o(ref_internal), .link(link));
    ppc_capture ppc_capture_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .sample_o(sample),
        .sample_ovr_o(sample_ovr), .sample_valid_o(sample_valid), .cal_busy_o(cal_busy),
        .link(link));
    ppc_assertions #(.CAL_CYCLES(CAL_N)) ppc_assertions_i (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ovr(link.ovr), .fwd_clk(link.fwd_clk), .rst_n(link.rst_n),
        .dev_rst_n_oe(link.dev_rst_n_oe), .cap_rst_n_oe(link.cap_rst_n_oe),
        .div_n_val(link.div_n_val), .div_n_oe(link.div_n_oe));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        code <= run_code ? code + 8'h25 : fixed_code;
        over <= ovr_force | (ovr_on & (code[2:0] == 3'h5));
        for (int i = 31; i > 0; i--) hist[i] <= hist[i-1];
        hist[0] <= {over, code};
    end
    always @(negedge clk_i) begin
        if (lat_on) begin
            check(32'(link.data), 32'(hist[28][7:0] ^ {tc_mode, 7'h00}));
            check(32'(link.ovr), 32'(hist[28][8]));
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_i);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        @(negedge clk_i);
        d = rdata;
    endtask
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (cal_busy !== 1'b0 && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        check(32'(k < lim), 32'h0000_0001);
    endtask
    task automatic count_edges(input int cyc, output int cnt);
        logic prev;
        repeat (4) @(negedge clk_i);
        cnt = 0;
        prev = link.fwd_clk;
        repeat (cyc) begin
            @(negedge clk_i);
            cnt += int'(link.fwd_clk !== prev);
            prev = link.fwd_clk;
        end
    endtask
    // length of a flag-high span, and words flagged valid in it
    task automatic ovr_span(input int lim, output int cnt, output int vld);
        cnt = 0;
        vld = 0;
        repeat (8) if (link.ovr !== 1'b1) @(posedge clk_i);
        while (link.ovr === 1'b1 && cnt < lim) begin
            @(posedge clk_i);
            cnt++;
            vld += int'(sample_valid === 1'b1);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        sys_rst_i = 1'b1;
        code = '0;
        over = 1'b0;
        addr = '0;
        wdata = '0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        run_code = 1'b1;
        fixed_code = 8'hA5;
        ovr_on = 1'b0;
        ovr_force = 1'b0;
        lat_on = 1'b0;
        tc_mode = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(REG_FREQ, rv);
        check(rv, 32'(FREQ_RESET));
        rd(REG_CTRL, rv);
        check(rv, 32'h0000_0000);
        rd(4'h2, rv);
        check(rv, 32'h0000_0000);
        rd(REG_STATUS, rv);
        check(rv, 32'h0000_0005);
        check(32'({link.ovr, link.fwd_clk, cal_active}), 32'h0000_0005);
        check(32'(ref_internal), 32'h0000_0000);
        wait_idle(CAL_N + 200);
        check(32'(cal_active), 32'h0000_0000);
        count_edges(20, n);
        check(32'(n), 32'h0000_000A);
        wr(REG_CTRL, 32'h0000_0006);
        count_edges(20, n);
        check(32'(n), 32'h0000_0014);
        ovr_on <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, 32'(ctrl_tab[i]));
            tc_mode = ctrl_tab[i][CTRL_TC_OE] & !ctrl_tab[i][CTRL_TC_VAL];
            repeat (40) @(posedge clk_i);
            lat_on = 1'b1;
            repeat (40) @(posedge clk_i);
            lat_on = 1'b0;
        end
        ovr_on <= 1'b0;
        run_code <= 1'b0;
        repeat (40) @(posedge clk_i);
        rd(REG_STATUS, rv);
        check(rv, 32'h0000_0002);
        rd(REG_DATA, rv);
        check(rv, 32'h0000_00A5);
        check(32'(sample), 32'h0000_00A5);
        check(32'(sample_ovr), 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_005E);
        repeat (2) @(posedge clk_i);
        check(32'(ref_internal), 32'h0000_0001);
        wr(REG_CTRL, 32'h0000_007E);
        repeat (2) @(posedge clk_i);
        check(32'(ref_internal), 32'h0000_0000);
        // exactly ten percent drift does not recalibrate
        wr(REG_FREQ, 32'h0000_6B6C);
        repeat (4) @(posedge clk_i);
        check(32'(cal_busy), 32'h0000_0000);
        wr(REG_FREQ, 32'h0000_6C66);
        ovr_span(CAL_N + 40, n, v);
        check(32'(n >= CAL_N && n <= CAL_N + 10), 32'h0000_0001);
        check(32'(v), 32'h0000_0000);
        wait_idle(100);
        ovr_force <= 1'b1;
        wr(REG_CTRL, 32'h0000_007F);
        rd(REG_CTRL, rv);
        check(rv, 32'h0000_007E);
        ovr_span(CAL_N + 40, n, v);
        check(32'(n), 32'(CAL_N + 40));
        check(32'(v), 32'h0000_0000);
        check(32'(sample_ovr), 32'h0000_0001);
        ovr_force <= 1'b0;
        wait_idle(60);
        report_and_stop();
    end
endmodule
